// File: pkg/status_out_pkg.sv
// Package: register map, field layout and function codes of the output selector
package status_out_pkg;
   // Register byte offsets on the APB bus
   localparam logic [11:0] REG_LIMIT_DISABLE = 12'h000;
   localparam logic [11:0] REG_TERMINAL_ASSIGN = 12'h004;
   localparam logic [11:0] REG_TORQUE_LEVEL = 12'h008;
   localparam logic [11:0] REG_TORQUE_TIME = 12'h00C;
   localparam logic [11:0] REG_IRQ_STATUS = 12'h010;
   localparam logic [11:0] REG_IRQ_MASK = 12'h014;
   localparam logic [11:0] REG_LINE_STATE = 12'h018;
   localparam logic [11:0] REG_ACTIVE_LIMIT = 12'h01C;
   // Reset values
   localparam logic [15:0] LIMIT_DISABLE_RST = 16'h0000;
   localparam logic [15:0] TERMINAL_ASSIGN_RST = 16'h0210;
   localparam logic [15:0] TORQUE_LEVEL_RST = 16'h0064;
   localparam logic [15:0] TORQUE_TIME_RST = 16'h000A;
   // Digit positions inside the limit-disable word
   localparam int FWD_DIS_BIT = 4;
   localparam int REV_DIS_BIT = 8;
   // Assignable terminal pairs and digit width
   localparam int NUM_PAIRS = 3;
   localparam int DIGIT_W = 4;
   // Unit of the torque detect time parameter: 1 ms at 50 MHz
   localparam int CLK_MHZ = 50;
   localparam int TIME_UNIT_US = 1000;
   localparam int TIME_UNIT_CYC = CLK_MHZ * TIME_UNIT_US;
   localparam logic [15:0] TICK_LAST = 16'(TIME_UNIT_CYC - 1);
   // Function codes of one assignment digit
   typedef enum logic [3:0] {
      FN_POS_DONE = 4'h0,
      FN_ROTATION = 4'h1,
      FN_READY = 4'h2,
      FN_TORQUE_LIMIT = 4'h3,
      FN_BRAKE = 4'h4,
      FN_INDEX = 4'h5,
      FN_TRAVEL = 4'h6,
      FN_EXCITE = 4'h7,
      FN_HOME = 4'h8,
      FN_TORQUE_DETECT = 4'h9,
      FN_REMOTE_ONE = 4'hA,
      FN_REMOTE_TWO = 4'hB
   } func_code_t;
   // Interrupt status bit positions
   localparam int IRQ_TRAVEL = 0;
   localparam int IRQ_TORQUE_DET = 1;
   localparam int IRQ_TORQUE_LIM = 2;
   localparam int IRQ_W = 3;
endpackage : status_out_pkg

// File: src/servo_status_output_select.sv
// Servo status output generation and terminal pair routing with APB registers
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module servo_status_output_select
   import status_out_pkg::*;
(
   input wire logic sys_clk,
   input wire logic arst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Drive status sources, active high
   input wire logic index_mark_in,
   input wire logic fwd_limit_in,
   input wire logic rev_limit_in,
   input wire logic servo_on_in,
   input wire logic pos_done_in,
   input wire logic rotation_in,
   input wire logic ready_in,
   input wire logic brake_release_in,
   input wire logic home_done_in,
   input wire logic remote_one_in,
   input wire logic remote_two_in,
   input wire logic [15:0] torque_ref_in,
   input wire logic [15:0] torque_lim_in,
   input wire logic [15:0] torque_actual_in,
   // Restart request: reloads restart-only settings
   input wire logic restart_in,
   // Terminal pairs, active low; interrupt line, active high
   output logic [NUM_PAIRS-1:0] pair_out_n,
   output logic irq
);

   // Overview of the block
   //
   // Register map, one aligned 32-bit word per register:
   //   limit disable    - written copy of the limit disable word
   //   terminal assign  - one function code per terminal pair
   //   torque level     - torque detect threshold, unsigned
   //   torque time      - torque detect qualification, in time units
   //   irq status       - sticky event bits, write one to clear
   //   irq mask         - same layout as the status word
   //   line state       - read only, function levels by code
   //   active limit     - read only, disable word now in force
   // Bits above the used field read as zero; writes ignore them.
   // Writes to the two read-only words are refused with pslverr.
   // An unmapped address is refused as well and changes nothing.
   //
   // Bus timing:
   //   Every access takes exactly one wait state.  The request is
   //   taken on the first access edge, pready follows one cycle
   //   later for one cycle only.  Read data is registered and
   //   stays on prdata until the next read replaces it.
   //   The fixed wait keeps the read mux out of the bus path, at
   //   the cost of one cycle per transfer, which is harmless at
   //   the low rate at which the host reconfigures the terminals.
   //
   // Terminal routing:
   //   Each pair shows one function level, inverted, so a pair is
   //   low while its function is active and high otherwise.
   //   A code above the last defined function leaves the pair
   //   high, the same as an inactive function, so that a stray
   //   write can never fake an active status towards the host.
   //   A function that no digit selects simply does not appear.
   //   Every pair is registered, so a pair lags its source by one
   //   clock; the host sees no combinational glitch from the mux.
   //
   // Travel clear:
   //   The line is on while no enabled travel limit is hit.  A
   //   disabled limit drops out of the term, so with both limits
   //   disabled the line stays on whatever the limit pins show.
   //   The disable word only takes hold on a restart request or
   //   on reset; writing it alone changes nothing on the lines.
   //   This keeps a half-finished setup from dropping a limit
   //   while the axis is moving.
   //
   // Torque detect:
   //   The actual torque must stay above the level for the set
   //   number of time units before the output goes active.  The
   //   time unit comes from a prescaler running on the system
   //   clock; a dip below the level restarts the whole count.
   //   A time of zero asserts one clock after the level is
   //   exceeded.  Long times are not shortened for simulation,
   //   so tests use small values.
   //
   // Torque limit:
   //   Active while the torque reference is strictly above the
   //   configured limit; equal values count as not limited.
   //
   // Interrupts:
   //   Three events set sticky status bits: loss of travel clear,
   //   rise of torque detect and rise of torque limit.  A new
   //   event in the same cycle as a clear wins, so no event can
   //   be lost to a badly timed acknowledge.  The irq line is high
   //   while any unmasked status bit is set; it is registered from the
   //   next status value, so it changes on the same edge as the status.
   //
   // Limitations:
   //   All source inputs are taken as synchronous to sys_clk; a
   //   source from another domain must be synchronised outside.
   //   The index pulse is passed straight through, so its width
   //   on the pair is the dwell time of the shaft at the mark,
   //   rounded to whole clocks.  A mark shorter than one clock
   //   can be missed, which limits the usable shaft speed.
   //   The restart input is level sensitive: while it is high the
   //   written disable word is copied into force every clock.

   // All state of the block
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [15:0] limit_disable_r;   // Written value
      logic [15:0] limit_active_r;    // Value in force since restart
      logic [15:0] assign_r;
      logic [15:0] level_r;
      logic [15:0] time_r;
      logic [IRQ_W-1:0] status_r;
      logic [IRQ_W-1:0] mask_r;
      logic [15:0] tick_cnt;          // Time unit prescaler
      logic [15:0] dwell_cnt;         // Units spent above level
      logic detect_r;                 // Qualified torque detect
      logic travel_r;                 // Last travel clear state
      logic tlim_r;                   // Last torque limit state
      logic [NUM_PAIRS-1:0] pair_n;
      logic irq;
   } state_t;

   state_t st_r;
   state_t st_nxt;

   // Active-high function level chosen by one digit
   function automatic logic pick(input logic [3:0] code,
                                 input logic [11:0] fn);
      logic res;
      res = 1'b0;
      if (code <= FN_REMOTE_TWO)
      begin
         res = fn[code];
      end
      return res;
   endfunction : pick

   // Decoded bus access phase
   logic acc;
   logic wr;
   logic rd;
   logic fwd_dis;
   logic rev_dis;
   logic travel_clear;   // High while no enabled limit is hit
   logic torque_lim;
   logic over_level;
   logic [11:0] fn_vec;  // Function levels indexed by code
   logic [IRQ_W-1:0] events;

   assign acc = psel & penable;
   assign wr = acc & pwrite;
   assign rd = acc & ~pwrite;

   // Only the value latched at restart steers the limits
   assign fwd_dis = st_r.limit_active_r[FWD_DIS_BIT];
   assign rev_dis = st_r.limit_active_r[REV_DIS_BIT];

   // Disabled limits drop out; both disabled leaves it clear
   assign travel_clear = ~((fwd_limit_in & ~fwd_dis)
                           | (rev_limit_in & ~rev_dis));

   assign torque_lim = torque_ref_in > torque_lim_in;
   assign over_level = torque_actual_in > st_r.level_r;

   // Source levels in function code order
   always_comb
   begin
      fn_vec = '0;
      fn_vec[FN_POS_DONE] = pos_done_in;
      fn_vec[FN_ROTATION] = rotation_in;
      fn_vec[FN_READY] = ready_in;
      fn_vec[FN_TORQUE_LIMIT] = torque_lim;
      fn_vec[FN_BRAKE] = brake_release_in;
      fn_vec[FN_INDEX] = index_mark_in;
      fn_vec[FN_TRAVEL] = travel_clear;
      fn_vec[FN_EXCITE] = servo_on_in;
      fn_vec[FN_HOME] = home_done_in;
      fn_vec[FN_TORQUE_DETECT] = st_r.detect_r;
      fn_vec[FN_REMOTE_ONE] = remote_one_in;
      fn_vec[FN_REMOTE_TWO] = remote_two_in;
   end

   // Events: travel lost, torque detect rise, torque limit rise
   assign events[IRQ_TRAVEL] = st_r.travel_r & ~travel_clear;
   // Rise is taken from the current state, not from st_nxt, so that
   // the status update does not read back through its own next value
   assign events[IRQ_TORQUE_DET] = over_level
                                   & (st_r.dwell_cnt >= st_r.time_r)
                                   & ~st_r.detect_r;
   assign events[IRQ_TORQUE_LIM] = torque_lim & ~st_r.tlim_r;

   // Next state of the whole block
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.pready = 1'b0;
      st_nxt.pslverr = 1'b0;
      st_nxt.travel_r = travel_clear;
      st_nxt.tlim_r = torque_lim;

      // Register writes take effect on the access cycle
      if (wr & ~st_r.pready)
      begin
         unique case (paddr)
            REG_LIMIT_DISABLE: st_nxt.limit_disable_r = pwdata[15:0];
            REG_TERMINAL_ASSIGN: st_nxt.assign_r = pwdata[15:0];
            REG_TORQUE_LEVEL: st_nxt.level_r = pwdata[15:0];
            REG_TORQUE_TIME: st_nxt.time_r = pwdata[15:0];
            REG_IRQ_MASK: st_nxt.mask_r = pwdata[IRQ_W-1:0];
            REG_IRQ_STATUS: st_nxt.status_r = st_r.status_r
                                              & ~pwdata[IRQ_W-1:0];
            REG_LINE_STATE, REG_ACTIVE_LIMIT: st_nxt.pslverr = 1'b1;
            default: st_nxt.pslverr = 1'b1;
         endcase
      end

      // Reads return one wait state later with registered data
      if (rd & ~st_r.pready)
      begin
         st_nxt.prdata = '0;
         unique case (paddr)
            REG_LIMIT_DISABLE: st_nxt.prdata[15:0] = st_r.limit_disable_r;
            REG_TERMINAL_ASSIGN: st_nxt.prdata[15:0] = st_r.assign_r;
            REG_TORQUE_LEVEL: st_nxt.prdata[15:0] = st_r.level_r;
            REG_TORQUE_TIME: st_nxt.prdata[15:0] = st_r.time_r;
            REG_IRQ_STATUS: st_nxt.prdata[IRQ_W-1:0] = st_r.status_r;
            REG_IRQ_MASK: st_nxt.prdata[IRQ_W-1:0] = st_r.mask_r;
            REG_LINE_STATE: st_nxt.prdata[11:0] = fn_vec;
            REG_ACTIVE_LIMIT: st_nxt.prdata[15:0] = st_r.limit_active_r;
            default: st_nxt.pslverr = 1'b1;
         endcase
      end

      // Every access finishes after exactly one wait state
      if (acc & ~st_r.pready)
      begin
         st_nxt.pready = 1'b1;
      end

      // Restart copies the written disable word into force
      if (restart_in)
      begin
         st_nxt.limit_active_r = st_r.limit_disable_r;
      end

      // Torque must stay above level for the set number of units
      if (!over_level)
      begin
         st_nxt.tick_cnt = '0;
         st_nxt.dwell_cnt = '0;
         st_nxt.detect_r = 1'b0;
      end
      else if (st_r.dwell_cnt >= st_r.time_r)
      begin
         st_nxt.detect_r = 1'b1;
      end
      else if (st_r.tick_cnt == TICK_LAST)
      begin
         st_nxt.tick_cnt = '0;
         st_nxt.dwell_cnt = st_r.dwell_cnt + 16'h0001;
      end
      else
      begin
         st_nxt.tick_cnt = st_r.tick_cnt + 16'h0001;
      end

      // Sticky status: a new event wins over a clear
      st_nxt.status_r = st_nxt.status_r | events;
      st_nxt.irq = |(st_nxt.status_r & st_r.mask_r);
      // Active-low terminals; only the digit's function appears
      for (int p = 0; p < NUM_PAIRS; p++)
      begin
         st_nxt.pair_n[p] = ~pick(st_r.assign_r[p*DIGIT_W +: DIGIT_W],
                                  fn_vec);
      end
   end

   // One register for all state
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_r <= '0;
         st_r.limit_disable_r <= LIMIT_DISABLE_RST;
         st_r.limit_active_r <= LIMIT_DISABLE_RST;
         st_r.assign_r <= TERMINAL_ASSIGN_RST;
         st_r.level_r <= TORQUE_LEVEL_RST;
         st_r.time_r <= TORQUE_TIME_RST;
         st_r.travel_r <= 1'b1;
         st_r.pair_n <= '1;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign prdata = st_r.prdata;
   assign pready = st_r.pready;
   assign pslverr = st_r.pslverr;
   assign pair_out_n = st_r.pair_n;
   assign irq = st_r.irq;

endmodule : servo_status_output_select
`default_nettype wire

// File: dv/status_out_sva.sv
// Checker: bus handshake and pair routing properties
`timescale 1ns/1ps
`default_nettype none
module status_out_sva
   import status_out_pkg::*;
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic index_mark_in,
   input wire logic fwd_limit_in,
   input wire logic rev_limit_in,
   input wire logic servo_on_in,
   input wire logic [NUM_PAIRS-1:0] pair_out_n
);
   // Shadow of the assignment word, loaded on the design's write edge
   logic [15:0] asg_r;
   logic acc;
   assign acc = psel && penable && !pready;
   // Mirrors the register so routing can be judged from ports alone
   always_ff @(posedge sys_clk or negedge arst_n)
      if (!arst_n)
         asg_r <= TERMINAL_ASSIGN_RST;
      else if (acc && pwrite && paddr == REG_TERMINAL_ASSIGN)
         asg_r <= pwdata[15:0];
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   a_one_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_one_wait: assert property (acc |=> pready)
      else $error("no answer after one wait state");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_ro_refuse: assert property (acc && pwrite && paddr == REG_LINE_STATE
      |=> pslverr) else $error("read-only write not refused");
   a_index_route: assert property (asg_r[3:0] == 4'h5
      |=> pair_out_n[0] == !$past(index_mark_in)) else $error("index");
   a_travel_on: assert property (asg_r[3:0] == 4'h6
      && !fwd_limit_in && !rev_limit_in |=> !pair_out_n[0])
      else $error("travel output not on");
   a_excite_route: assert property (asg_r[3:0] == 4'h7
      |=> pair_out_n[0] == !$past(servo_on_in)) else $error("excite");
   a_bad_code: assert property (asg_r[7:4] > 4'hB
      |=> pair_out_n[1]) else $error("unknown code drove a pair");
   c_refused: cover property (pslverr);
   c_index: cover property (asg_r[3:0] == 4'h5 && index_mark_in);
   c_travel: cover property (asg_r[3:0] == 4'h6 && fwd_limit_in);
endmodule : status_out_sva
`default_nettype wire

// File: dv/host_ctrl_model.sv
// Host controller model: halts references while travel output is off
`timescale 1ns/1ps
`default_nettype none
module host_ctrl_model
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic travel_n,
   output logic halt_refs
);
   // Registered, so halt_refs follows travel_n one clock later, a one-cycle glitch included
   always_ff @(posedge sys_clk or negedge arst_n)
      if (!arst_n)
         halt_refs <= 1'b1;
      else
         halt_refs <= travel_n;
endmodule : host_ctrl_model
`default_nettype wire

// File: dv/tb_top.sv
// Testbench: register access, terminal routing and interrupt checks
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import status_out_pkg::*;
   logic sys_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rdat;
   logic pready, pslverr, irq, er, halt, rs_q = 0, rv = 0;
   // One bit per function code drives that code's source
   logic [11:0] src = '0;
   logic [2:0] pair_out_n;
   // Status bit 0 reads set: the forward limit is hit from the start,
   // so travel clear is lost on the first edge after reset
   logic [31:0] rst_v [6] = '{32'h0, 32'h0210, 32'h0064, 32'h000A, 32'h1,
      32'h0};
   int fails = 0, tests_run = 0;
   servo_status_output_select uut (.sys_clk(sys_clk), .arst_n(arst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .index_mark_in(src[5]), .fwd_limit_in(!src[6]), .rev_limit_in(rv),
      .servo_on_in(src[7]), .pos_done_in(src[0]), .rotation_in(src[1]),
      .ready_in(src[2]), .brake_release_in(src[4]), .home_done_in(src[8]),
      .remote_one_in(src[10]), .remote_two_in(src[11]),
      // Levels sit one step above or exactly at their thresholds
      .torque_ref_in(src[3] ? 16'h0009 : 16'h0008),
      .torque_lim_in(16'h0008),
      .torque_actual_in(src[9] ? 16'h0065 : 16'h0064),
      .restart_in(rs_q), .pair_out_n(pair_out_n), .irq(irq));
   host_ctrl_model host (.sys_clk(sys_clk), .arst_n(arst_n),
      .travel_n(pair_out_n[0]), .halt_refs(halt));
   initial forever #10 sys_clk = ~sys_clk;
   task automatic chk(input string n, input logic [31:0] e, g);
      tests_run++;
      if (g !== e)
      begin
         $display("[ERR] %s expected %h seen %h", n, e, g);
         fails++;
      end
   endtask : chk
   // Setup, then access held until pready is sampled high
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int n = 0;
      @(posedge sys_clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n == 50)
         fails++;
      rdat = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : xfer
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      xfer(0, a, 32'h0);
      chk("prdata", e, rdat);
   endtask : rd
   // Outputs settle within a few cycles, torque detect path included
   task automatic pchk(input logic [2:0] e);
      repeat (4) @(posedge sys_clk);
      chk("pair_out_n", {29'h0, e}, {29'h0, pair_out_n});
   endtask : pchk
   task automatic restart;
      @(posedge sys_clk);
      rs_q <= 1;
      @(posedge sys_clk);
      rs_q <= 0;
   endtask : restart
   task automatic close_out;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : close_out
   // Watchdog far beyond the few hundred cycles the run needs
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      fails++;
      close_out();
   end
   initial
   begin
      repeat (20) @(posedge sys_clk);
      arst_n <= 1;
      for (int i = 0; i < 6; i++)
         rd(12'(4 * i), rst_v[i]);
      xfer(1, REG_LINE_STATE, 32'h1);
      chk("pslverr", 32'h1, er);
      xfer(0, 12'h020, 32'h0);
      chk("pslverr", 32'h1, er);
      xfer(1, REG_TORQUE_TIME, 32'h0);
      // Every code on the first pair, the others hold undefined code F
      for (int c = 0; c < 12; c++)
      begin
         xfer(1, REG_TERMINAL_ASSIGN, 32'h0FF0 | c);
         src <= 12'h001 << c;
         pchk(3'b110);
         src <= '0;
         pchk(3'b111);
      end
      xfer(1, REG_TERMINAL_ASSIGN, 32'h05F5);
      src <= 12'h020;
      pchk(3'b010);
      src <= '0;
      xfer(1, REG_TERMINAL_ASSIGN, 32'h0006);
      pchk(3'b111);
      chk("halt_refs", 32'h1, halt);
      xfer(1, REG_LIMIT_DISABLE, 32'h0010);
      pchk(3'b111);
      restart();
      pchk(3'b110);
      rd(REG_ACTIVE_LIMIT, 32'h0010);
      rv <= 1;
      pchk(3'b111);
      xfer(1, REG_LIMIT_DISABLE, 32'h0110);
      restart();
      pchk(3'b110);
      // Losing travel clear raises status bit zero
      xfer(1, REG_IRQ_STATUS, 32'h7);
      xfer(1, REG_IRQ_MASK, 32'h1);
      xfer(1, REG_LIMIT_DISABLE, 32'h0);
      restart();
      pchk(3'b111);
      chk("irq", 32'h1, irq);
      rd(REG_IRQ_STATUS, 32'h1);
      xfer(1, REG_IRQ_MASK, 32'h0);
      pchk(3'b111);
      chk("irq", 32'h0, irq);
      xfer(1, REG_IRQ_STATUS, 32'h1);
      xfer(1, REG_IRQ_MASK, 32'h1);
      pchk(3'b111);
      chk("irq", 32'h0, irq);
      rd(REG_IRQ_STATUS, 32'h0);
      close_out();
   end
endmodule : tb_top
bind servo_status_output_select status_out_sva sva_i (.sys_clk(sys_clk),
   .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .index_mark_in(index_mark_in), .fwd_limit_in(fwd_limit_in),
   .rev_limit_in(rev_limit_in), .servo_on_in(servo_on_in),
   .pair_out_n(pair_out_n));
`default_nettype wire
